// ### testbench/ssic_cpu_model.sv
// Behavioural CPU that takes vector requests and returns from routines.
`timescale 1ns/100ps
module ssic_cpu_model
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic irq_req,
  input wire logic [3:0] ack_wait,
  input wire logic ret_req,
  output logic cpu_ack,
  output logic return_from_irq
);
  logic [3:0] wait_r;
  logic [1:0] hold_r;
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      wait_r <= 4'h0;
      hold_r <= 2'h0;
      cpu_ack <= 1'b0;
      return_from_irq <= 1'b0;
    end
    else
    begin
      return_from_irq <= ret_req;
      cpu_ack <= 1'b0;
      // The hold-off stops a second ack on the lagging request level.
      if (hold_r != 2'h0)
        hold_r <= hold_r - 2'h1;
      else if (irq_req)
      begin
        wait_r <= (wait_r == ack_wait) ? 4'h0 : wait_r + 4'h1;
        cpu_ack <= (wait_r == ack_wait);
        hold_r <= (wait_r == ack_wait) ? 2'h2 : 2'h0;
      end
      else
        wait_r <= 4'h0;
    end
endmodule // ssic_cpu_model

// ### testbench/ssic_top_asserts.sv
// Concurrent checks on the interrupt controller ports.
`timescale 1ns/100ps
module ssic_top_asserts
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_req,
  input wire logic [2:0] irq_index,
  input wire logic [7:0] irq_vector,
  input wire logic cpu_ack,
  input wire logic return_from_irq,
  input wire logic [2:0] in_service
);
  logic [7:0] en_r;
  // Shadow of the enable register, so no design internals are needed.
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      en_r <= 8'h00;
    else if (reg_wr && reg_addr == 3'h0)
      en_r <= reg_wdata;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_take;
    irq_req && cpu_ack;
  endsequence
  a_vec_index:
    assert property (irq_req |-> irq_vector == 8'h03 + {2'h0, irq_index, 3'h0})
      else $error("vector does not match index");
  a_ack_drop:
    assert property (s_take |=> !irq_req) else $error("request held");
  a_warn_top:
    assert property (s_take ##0 irq_index == 3'h5 |=> in_service[2])
      else $error("warning not in service");
  a_one_level:
    assert property (s_take ##0 in_service == 3'h0 ##0 irq_index != 3'h5
      |=> in_service[0] != in_service[1]) else $error("level not marked");
  a_high_busy:
    assert property (in_service[1] && !in_service[2] |-> !irq_req ||
      irq_index == 3'h5) else $error("same level preempted");
  a_warn_busy:
    assert property (in_service[2] |-> !irq_req) else $error("warn preempted");
  a_ret_clear:
    assert property (return_from_irq && !cpu_ack && in_service == 3'h1
      |=> in_service == 3'h0) else $error("return kept level");
  a_en_read:
    assert property (reg_rd && reg_addr == 3'h0 |=> reg_rdata == $past(en_r))
      else $error("enable readback wrong");
  a_global_off:
    assert property (irq_req && !en_r[7] && !$past(en_r[7]) |->
      irq_index == 3'h5) else $error("request with global off");
endmodule // ssic_top_asserts

// ### testbench/test_ssic_top.sv
// Self-checking bench for the six source interrupt controller.
`timescale 1ns/100ps
module test_ssic_top;
  logic ref_clk, arst_n, mc_tick, ext0_pin_n, ext1_pin_n, irq_req;
  logic tmr0_overflow, tmr1_overflow, uart_rx_done, uart_tx_done;
  logic supply_low, reg_wr, reg_rd, cpu_ack, return_from_irq, ret_req;
  logic [2:0] reg_addr, irq_index, in_service;
  logic [7:0] reg_wdata, reg_rdata, irq_vector;
  logic [3:0] ack_wait, tick_cnt;
  int err_count, num_checks, q[$], p, ip, w;
  ssic_top ssic_top_i (.ref_clk, .arst_n, .mc_tick, .ext0_pin_n,
    .ext1_pin_n, .tmr0_overflow, .tmr1_overflow, .uart_rx_done,
    .uart_tx_done, .supply_low, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq_req, .irq_index, .irq_vector, .cpu_ack,
    .return_from_irq, .in_service);
  ssic_cpu_model ssic_cpu_model_i (.ref_clk, .arst_n, .irq_req,
    .ack_wait, .ret_req, .cpu_ack, .return_from_irq);
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    tick_cnt <= tick_cnt + 4'h1;
    mc_tick <= (tick_cnt[1:0] == 2'h3);
  end
  task automatic summarize();
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic wait_irq(int i, logic [2:0] s);
    int n;
    for (n = 0; n < 200 && irq_req !== 1'b1; n++) cyc(1);
    chk("irq_index", 8'(i), {5'h0, irq_index});
    chk("irq_vector", 8'h03 + 8'(i * 8), irq_vector);
    for (n = 0; n < 40 && cpu_ack !== 1'b1; n++) cyc(1);
    cyc(1);
    chk("in_service", {5'h0, s}, {5'h0, in_service});
  endtask
  task automatic ret();
    @(posedge ref_clk);
    ret_req <= 1'b1;
    @(posedge ref_clk);
    ret_req <= 1'b0;
    cyc(2);
  endtask
  // Reference arbiter: high level first, then natural order.
  function automatic int win(int p, int hp);
    for (int l = 1; l >= 0; l--)
      for (int i = 0; i < 5; i++)
        if (p[i] && hp[i] == l)
          return i;
    return 0;
  endfunction
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    summarize();
  end
  initial
  begin
    {arst_n, mc_tick, ext0_pin_n, ext1_pin_n} = 4'h3;
    {tmr0_overflow, tmr1_overflow, uart_rx_done, uart_tx_done} = 4'h0;
    {supply_low, reg_wr, reg_rd, ret_req} = 4'h0;
    {reg_addr, reg_wdata, tick_cnt, ack_wait} = 19'h0;
    err_count = 0;
    num_checks = 0;
    w = $urandom(32'h4221);
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    w = $urandom & 32'h7F;
    wr(3'h0, w[7:0]);
    rd(3'h0, w[7:0]);
    wr(3'h0, 8'h00);
    @(posedge ref_clk);
    {tmr1_overflow, uart_rx_done, uart_tx_done} <= 3'h7;
    @(posedge ref_clk);
    {tmr1_overflow, uart_rx_done, uart_tx_done} <= 3'h0;
    rd(3'h2, 8'h80);
    rd(3'h3, 8'h03);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    ip = $urandom & 32'h1F;
    ack_wait <= 4'($urandom % 6);
    wr(3'h1, 8'(ip));
    rd(3'h1, 8'(ip));
    wr(3'h2, 8'hAF);
    wr(3'h3, 8'h03);
    wr(3'h0, 8'h9F);
    for (p = 31; p != 0; p[w] = 1'b0)
    begin
      w = win(p, ip);
      q.push_back(w);
    end
    foreach (q[k])
    begin
      wait_irq(q[k], ip[q[k]] ? 3'h2 : 3'h1);
      if (q[k] == 4) wr(3'h3, 8'h00);
      ret();
    end
    rd(3'h2, 8'h05);
    wr(3'h1, 8'h02);
    wr(3'h0, 8'h83);
    wr(3'h2, 8'h03);
    wait_irq(0, 3'h1);
    @(posedge ref_clk);
    tmr0_overflow <= 1'b1;
    @(posedge ref_clk);
    tmr0_overflow <= 1'b0;
    wait_irq(1, 3'h3);
    ret();
    ret();
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h84);
    wr(3'h2, 8'h04);
    ack_wait <= 4'hF;
    ext1_pin_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    ext1_pin_n <= 1'b1;
    wait_irq(2, 3'h1);
    ret();
    wr(3'h2, 8'h00);
    ack_wait <= 4'h2;
    ext1_pin_n <= 1'b0;
    wait_irq(2, 3'h1);
    ret();
    wait_irq(2, 3'h1);
    ext1_pin_n <= 1'b1;
    cyc(8);
    ret();
    cyc(12);
    chk("irq_req", 8'h00, {7'h0, irq_req});
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h20);
    rd(3'h4, 8'h00);
    supply_low <= 1'b1;
    cyc(6);
    supply_low <= 1'b0;
    cyc(4);
    rd(3'h4, 8'h20);
    rd(3'h4, 8'h00);
    wr(3'h4, 8'h08);
    supply_low <= 1'b1;
    wait_irq(5, 3'h4);
    supply_low <= 1'b0;
    cyc(4);
    rd(3'h4, 8'h28);
    ret();
    summarize();
  end
endmodule // test_ssic_top
bind ssic_top ssic_top_asserts ssic_top_asserts_i (.ref_clk, .arst_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_req,
  .irq_index, .irq_vector, .cpu_ack, .return_from_irq, .in_service);

// ### verilog/ssic_consts.svh
// Constants for the six source interrupt controller.
`ifndef SSIC_CONSTS_SVH
`define SSIC_CONSTS_SVH
`define SSIC_ADDR_ENABLE 3'h0
`define SSIC_ADDR_PRIO 3'h1
`define SSIC_ADDR_TIMER_CTL 3'h2
`define SSIC_ADDR_UART_CTL 3'h3
`define SSIC_ADDR_POWER_CTL 3'h4
`define SSIC_IE_EXT0 0
`define SSIC_IE_TMR0 1
`define SSIC_IE_EXT1 2
`define SSIC_IE_TMR1 3
`define SSIC_IE_UART 4
`define SSIC_IE_GLOBAL 7
`define SSIC_TC_EXT0_EDGE 0
`define SSIC_TC_EXT0_FLAG 1
`define SSIC_TC_EXT1_EDGE 2
`define SSIC_TC_EXT1_FLAG 3
`define SSIC_TC_TMR0_FLAG 5
`define SSIC_TC_TMR1_FLAG 7
`define SSIC_UC_RX 0
`define SSIC_UC_TX 1
`define SSIC_PC_WARN_EN 3
`define SSIC_PC_WARN_FLAG 5
`define SSIC_RESET_BYTE 8'h00
`define SSIC_PRIO_MASK 8'h1F
`define SSIC_VEC_BASE 8'h03
`define SSIC_VEC_STEP 8'h08
`endif

// ### verilog/ssic_pkg.sv
// Types shared by the interrupt controller.
package ssic_pkg;
  // Vector index in natural order; the warning source takes index 5.
  typedef enum logic [2:0]
  {
    SSIC_SRC_EXT0,
    SSIC_SRC_TMR0,
    SSIC_SRC_EXT1,
    SSIC_SRC_TMR1,
    SSIC_SRC_UART,
    SSIC_SRC_WARN
  } ssic_src_t;
  typedef enum logic [1:0]
  {
    SSIC_ST_IDLE,
    SSIC_ST_REQ
  } ssic_state_t;
endpackage

// ### verilog/ssic_top.sv
// Six source interrupt controller with three priority levels.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "ssic_consts.svh"
module ssic_top
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic mc_tick,
  input wire logic ext0_pin_n,
  input wire logic ext1_pin_n,
  input wire logic tmr0_overflow,
  input wire logic tmr1_overflow,
  input wire logic uart_rx_done,
  input wire logic uart_tx_done,
  input wire logic supply_low,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq_req,
  output logic [2:0] irq_index,
  output logic [7:0] irq_vector,
  input wire logic cpu_ack,
  input wire logic return_from_irq,
  output logic [2:0] in_service
);
  import ssic_pkg::*;

  logic ext0_s1_r, ext0_s2_r, ext1_s1_r, ext1_s2_r;
  logic low_s1_r, low_s2_r;
  logic ext0_smp_r, ext1_smp_r, ext0_prev_r, ext1_prev_r;
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_priority_reg;
  logic ext0_edge_mode, ext1_edge_mode;
  logic ext0_flag, ext1_flag, tmr0_overflow_flag, tmr1_overflow_flag;
  logic uart_rx_done_flag, uart_tx_done_flag;
  logic power_warn_flag, power_warn_enable;
  logic ext0_lock_r, ext1_lock_r;
  logic [2:0] in_service_r;
  ssic_state_t state_r;
  ssic_src_t win_src;
  logic win_valid, win_hi, win_warn;
  logic [5:0] pend;
  logic [5:0] hi_req, lo_req;
  logic [2:0] src_level_r;
  logic wr_tc, wr_uc, wr_pc, ack_ok;

  // Pins come from outside; two flops before any logic looks at them.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext0_s1_r <= 1'b1;
      ext0_s2_r <= 1'b1;
      ext1_s1_r <= 1'b1;
      ext1_s2_r <= 1'b1;
      low_s1_r <= 1'b0;
      low_s2_r <= 1'b0;
    end
    else
    begin
      ext0_s1_r <= ext0_pin_n;
      ext0_s2_r <= ext0_s1_r;
      ext1_s1_r <= ext1_pin_n;
      ext1_s2_r <= ext1_s1_r;
      low_s1_r <= supply_low;
      low_s2_r <= low_s1_r;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext0_smp_r <= 1'b1;
      ext1_smp_r <= 1'b1;
      ext0_prev_r <= 1'b1;
      ext1_prev_r <= 1'b1;
    end
    else if (mc_tick)
    begin
      if (irq_enable_reg[`SSIC_IE_EXT0])
      begin
        ext0_prev_r <= ext0_smp_r;
        ext0_smp_r <= ext0_s2_r;
      end
      if (irq_enable_reg[`SSIC_IE_EXT1])
      begin
        ext1_prev_r <= ext1_smp_r;
        ext1_smp_r <= ext1_s2_r;
      end
    end
  end

  assign wr_tc = reg_wr && (reg_addr == `SSIC_ADDR_TIMER_CTL);
  assign wr_uc = reg_wr && (reg_addr == `SSIC_ADDR_UART_CTL);
  assign wr_pc = reg_wr && (reg_addr == `SSIC_ADDR_POWER_CTL);
  // An ack only counts against a live, presented winner, so a stray ack
  // can never clear the default source's flag.
  assign ack_ok = cpu_ack && irq_req && win_valid
    && (state_r == SSIC_ST_REQ);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_enable_reg <= `SSIC_RESET_BYTE;
    else if (reg_wr && reg_addr == `SSIC_ADDR_ENABLE)
      irq_enable_reg <= reg_wdata;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_priority_reg <= `SSIC_RESET_BYTE;
    else if (reg_wr && reg_addr == `SSIC_ADDR_PRIO)
      irq_priority_reg <= reg_wdata & `SSIC_PRIO_MASK;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext0_edge_mode <= 1'b0;
      ext1_edge_mode <= 1'b0;
    end
    else if (wr_tc)
    begin
      ext0_edge_mode <= reg_wdata[`SSIC_TC_EXT0_EDGE];
      ext1_edge_mode <= reg_wdata[`SSIC_TC_EXT1_EDGE];
    end
  end

  // Edge mode ignores the pin from detection until a return comes while src_level_r still names the source.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext0_lock_r <= 1'b0;
      ext1_lock_r <= 1'b0;
    end
    else
    begin
      if (ext0_flag && ext0_edge_mode)
        ext0_lock_r <= 1'b1;
      else if (return_from_irq && src_level_r == 3'(SSIC_SRC_EXT0))
        ext0_lock_r <= 1'b0;
      if (ext1_flag && ext1_edge_mode)
        ext1_lock_r <= 1'b1;
      else if (return_from_irq && src_level_r == 3'(SSIC_SRC_EXT1))
        ext1_lock_r <= 1'b0;
    end
  end

  // External flags: level mode follows the sampled pin, edge mode latches.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext0_flag <= 1'b0;
      ext1_flag <= 1'b0;
    end
    else
    begin
      if (ack_ok && win_src == SSIC_SRC_EXT0)
        ext0_flag <= 1'b0;
      else if (wr_tc)
        ext0_flag <= reg_wdata[`SSIC_TC_EXT0_FLAG];
      else if (!ext0_edge_mode && irq_enable_reg[`SSIC_IE_EXT0])
        ext0_flag <= !ext0_smp_r;
      else if (ext0_edge_mode && !ext0_lock_r && ext0_prev_r && !ext0_smp_r)
        ext0_flag <= 1'b1;
      if (ack_ok && win_src == SSIC_SRC_EXT1)
        ext1_flag <= 1'b0;
      else if (wr_tc)
        ext1_flag <= reg_wdata[`SSIC_TC_EXT1_FLAG];
      else if (!ext1_edge_mode && irq_enable_reg[`SSIC_IE_EXT1])
        ext1_flag <= !ext1_smp_r;
      else if (ext1_edge_mode && !ext1_lock_r && ext1_prev_r && !ext1_smp_r)
        ext1_flag <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tmr0_overflow_flag <= 1'b0;
      tmr1_overflow_flag <= 1'b0;
    end
    else
    begin
      if (ack_ok && win_src == SSIC_SRC_TMR0)
        tmr0_overflow_flag <= 1'b0;
      else if (tmr0_overflow)
        tmr0_overflow_flag <= 1'b1;
      else if (wr_tc)
        tmr0_overflow_flag <= reg_wdata[`SSIC_TC_TMR0_FLAG];
      if (ack_ok && win_src == SSIC_SRC_TMR1)
        tmr1_overflow_flag <= 1'b0;
      else if (tmr1_overflow)
        tmr1_overflow_flag <= 1'b1;
      else if (wr_tc)
        tmr1_overflow_flag <= reg_wdata[`SSIC_TC_TMR1_FLAG];
    end
  end

  // serial flags, cleared by software only
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      uart_rx_done_flag <= 1'b0;
      uart_tx_done_flag <= 1'b0;
    end
    else
    begin
      if (uart_rx_done)
        uart_rx_done_flag <= 1'b1;
      else if (wr_uc)
        uart_rx_done_flag <= reg_wdata[`SSIC_UC_RX];
      if (uart_tx_done)
        uart_tx_done_flag <= 1'b1;
      else if (wr_uc)
        uart_tx_done_flag <= reg_wdata[`SSIC_UC_TX];
    end
  end

  // Warning flag: set wins over the read clear, so a low supply refills it.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      power_warn_flag <= 1'b0;
      power_warn_enable <= 1'b0;
    end
    else
    begin
      if (wr_pc)
        power_warn_enable <= reg_wdata[`SSIC_PC_WARN_EN];
      // set while low, clear on read
      if (low_s2_r)
        power_warn_flag <= 1'b1;
      else if (reg_rd && reg_addr == `SSIC_ADDR_POWER_CTL)
        power_warn_flag <= 1'b0;
    end
  end

  assign pend[0] = irq_enable_reg[`SSIC_IE_GLOBAL]
    && irq_enable_reg[`SSIC_IE_EXT0] && ext0_flag;
  assign pend[1] = irq_enable_reg[`SSIC_IE_GLOBAL]
    && irq_enable_reg[`SSIC_IE_TMR0] && tmr0_overflow_flag;
  assign pend[2] = irq_enable_reg[`SSIC_IE_GLOBAL]
    && irq_enable_reg[`SSIC_IE_EXT1] && ext1_flag;
  assign pend[3] = irq_enable_reg[`SSIC_IE_GLOBAL]
    && irq_enable_reg[`SSIC_IE_TMR1] && tmr1_overflow_flag;
  assign pend[4] = irq_enable_reg[`SSIC_IE_GLOBAL]
    && irq_enable_reg[`SSIC_IE_UART]
    && (uart_rx_done_flag || uart_tx_done_flag);
  assign pend[5] = power_warn_enable && power_warn_flag;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_split
      assign hi_req[gi] = pend[gi] && irq_priority_reg[gi];
      assign lo_req[gi] = pend[gi] && !irq_priority_reg[gi];
    end
  endgenerate
  assign hi_req[5] = 1'b0;
  assign lo_req[5] = 1'b0;

  always_comb
  begin
    win_src = SSIC_SRC_EXT0;
    win_valid = 1'b0;
    win_hi = 1'b0;
    win_warn = 1'b0;
    if (pend[5] && !in_service_r[2])
    begin
      win_src = SSIC_SRC_WARN;
      win_valid = 1'b1;
      win_warn = 1'b1;
    end
    else if (|hi_req && !in_service_r[2] && !in_service_r[1])
    begin
      win_valid = 1'b1;
      win_hi = 1'b1;
      for (int i = 4; i >= 0; i--)
        if (hi_req[i])
          win_src = ssic_src_t'(3'(i));
    end
    else if (|lo_req && in_service_r == 3'h0)
    begin
      win_valid = 1'b1;
      for (int i = 4; i >= 0; i--)
        if (lo_req[i])
          win_src = ssic_src_t'(3'(i));
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= SSIC_ST_IDLE;
      irq_req <= 1'b0;
      irq_index <= 3'h0;
      irq_vector <= 8'h00;
    end
    else
    begin
      case (state_r)
        SSIC_ST_IDLE:
          state_r <= SSIC_ST_REQ;
        SSIC_ST_REQ:
          if (ack_ok)
            state_r <= SSIC_ST_IDLE;
        default:
          state_r <= SSIC_ST_IDLE;
      endcase
      // The request tracks the live winner so a dropped level source
      // withdraws itself before the CPU takes it.
      irq_req <= win_valid && !ack_ok && !return_from_irq;
      irq_index <= 3'(win_src);
      irq_vector <= `SSIC_VEC_BASE + 8'(`SSIC_VEC_STEP * 8'(win_src));
    end
  end

  // in-service levels: bit 0 low, 1 high, 2 warning
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_service_r <= 3'h0;
      src_level_r <= 3'h0;
    end
    else if (ack_ok && win_valid && irq_req)
    begin
      src_level_r <= 3'(win_src);
      if (win_warn)
        in_service_r[2] <= 1'b1;
      else if (win_hi)
        in_service_r[1] <= 1'b1;
      else
        in_service_r[0] <= 1'b1;
    end
    else if (return_from_irq)
    begin
      if (in_service_r[2])
        in_service_r[2] <= 1'b0;
      else if (in_service_r[1])
        in_service_r[1] <= 1'b0;
      else
        in_service_r[0] <= 1'b0;
    end
  end

  assign in_service = in_service_r;

  // Read data stands one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      case (reg_addr)
        `SSIC_ADDR_ENABLE: reg_rdata <= irq_enable_reg;
        `SSIC_ADDR_PRIO: reg_rdata <= irq_priority_reg;
        `SSIC_ADDR_TIMER_CTL: reg_rdata <= {tmr1_overflow_flag, 1'b0,
          tmr0_overflow_flag, 1'b0, ext1_flag, ext1_edge_mode,
          ext0_flag, ext0_edge_mode};
        `SSIC_ADDR_UART_CTL: reg_rdata <= {6'h00, uart_tx_done_flag,
          uart_rx_done_flag};
        `SSIC_ADDR_POWER_CTL: reg_rdata <= {2'h0, power_warn_flag, 1'b0,
          power_warn_enable, 3'h0};
        default: reg_rdata <= 8'h00;
      endcase
    else
      reg_rdata <= 8'h00;
  end
endmodule // ssic_top
